// ---- hw/fpps_unit.sv ----
// Flexible PPS output and target time comparator with APB registers
`include "fpps_params.svh"
module fpps_unit
   import fpps_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Running system time
   input wire fpps_time_t sys_time,
   // Pulse output and interrupt
   output logic pps_out,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic time_reached(input fpps_time_t now,
                                         input fpps_time_t tgt);
      time_reached = (now.sec > tgt.sec) ||
                     ((now.sec == tgt.sec) && (now.ns >= tgt.ns));
   endfunction

   function automatic fpps_time_t time_add(input fpps_time_t t,
                                           input logic [31:0] n);
      time_add.sec = t.sec;
      time_add.ns = t.ns + n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   fpps_mode_t mode;
   fpps_time_t target;
   logic [31:0] width;
   logic [31:0] interval;
   logic busy;
   logic [1:0] status;
   logic [1:0] mask;
   fpps_state_t state;
   logic [31:0] high_cnt;
   logic [31:0] low_cnt;
   logic stop_pending;
   logic hit;
   logic wr;
   logic rd;
   logic [3:0] cmd_wr;
   logic mode_wr;
   logic stat_rd;
   logic pulse_role;
   logic int_role;
   logic [1:0] next_status;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign cmd_wr = (wr && paddr == `FPPS_ADDR_CTRL) ?
                   pwdata[`FPPS_CMD_MSB:`FPPS_CMD_LSB] : 4'h0;
   assign mode_wr = wr && (paddr == `FPPS_ADDR_CTRL) &&
                    (pwdata[`FPPS_MODE_MSB:`FPPS_MODE_LSB] != mode);
   assign stat_rd = rd && (paddr == `FPPS_ADDR_STAT);
   assign pulse_role = (mode == FPPS_MODE_BOTH) ||
                       (mode == FPPS_MODE_PULSE);
   assign int_role = (mode == FPPS_MODE_INT) ||
                     (mode == FPPS_MODE_BOTH);
   assign hit = busy && time_reached(sys_time, target);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= fpps_mode_t'(`FPPS_MODE_RST);
         width <= `FPPS_WIDTH_RST;
         interval <= `FPPS_INTVL_RST;
         target <= '0;
         mask <= 2'h0;
      end else if (wr) begin
         unique case (paddr)
            `FPPS_ADDR_CTRL: begin
               mode <= fpps_mode_t'(pwdata[`FPPS_MODE_MSB:`FPPS_MODE_LSB]);
            end
            `FPPS_ADDR_TSEC: begin
               target.sec <= pwdata;
            end
            `FPPS_ADDR_TNS: begin
               target.ns <= {1'b0, pwdata[30:0]};
            end
            `FPPS_ADDR_WIDTH: begin
               width <= pwdata;
            end
            `FPPS_ADDR_INTVL: begin
               interval <= pwdata;
            end
            `FPPS_ADDR_MASK: begin
               mask <= pwdata[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Target pending flag: set on a nanoseconds write, cleared on a match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
      end else if (wr && paddr == `FPPS_ADDR_TNS) begin
         busy <= 1'b1;
      end else if (mode_wr && mode == FPPS_MODE_INT) begin
         busy <= 1'b0;
      end else if (hit && !(stop_pending && pulse_role &&
                            state == FPPS_HIGH)) begin
         // A stop match inside a high phase stays armed for the low phase
         busy <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulse sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= FPPS_IDLE;
         pps_out <= 1'b0;
         high_cnt <= 32'h0;
         low_cnt <= 32'h0;
         stop_pending <= 1'b0;
      end else begin
         if (cmd_wr == FPPS_CMD_STOP_AT) begin
            stop_pending <= 1'b1;
         end else if (cmd_wr == FPPS_CMD_UNSTOP) begin
            stop_pending <= 1'b0;
         end
         if (cmd_wr == FPPS_CMD_SINGLE) begin
            state <= FPPS_WAIT_SINGLE;
         end else if (cmd_wr == FPPS_CMD_TRAIN) begin
            state <= FPPS_WAIT_TRAIN;
         end else if (cmd_wr == FPPS_CMD_CANCEL &&
                      (state == FPPS_WAIT_SINGLE ||
                       state == FPPS_WAIT_TRAIN)) begin
            state <= FPPS_IDLE;
         end else if (cmd_wr == FPPS_CMD_STOP_NOW) begin
            state <= FPPS_IDLE;
            pps_out <= 1'b0;
            stop_pending <= 1'b0;
         end else begin
            unique case (state)
               FPPS_IDLE: begin
                  pps_out <= 1'b0;
               end
               FPPS_WAIT_SINGLE, FPPS_WAIT_TRAIN: begin
                  if (hit && pulse_role) begin
                     pps_out <= 1'b1;
                     high_cnt <= width;
                     low_cnt <= interval - width;
                     state <= (state == FPPS_WAIT_TRAIN) ? FPPS_HIGH :
                              FPPS_HIGH;
                     stop_pending <= 1'b0;
                     if (state == FPPS_WAIT_SINGLE) begin
                        low_cnt <= 32'h0;
                     end
                  end
               end
               FPPS_HIGH: begin
                  if (high_cnt <= 32'h1) begin
                     pps_out <= 1'b0;
                     state <= (low_cnt == 32'h0) ? FPPS_IDLE : FPPS_LOW;
                  end else begin
                     high_cnt <= high_cnt - 32'h1;
                  end
               end
               FPPS_LOW: begin
                  if (stop_pending && hit && pulse_role) begin
                     state <= FPPS_IDLE;
                     stop_pending <= 1'b0;
                  end else if (low_cnt <= 32'h1) begin
                     pps_out <= 1'b1;
                     state <= FPPS_HIGH;
                     high_cnt <= width;
                     low_cnt <= interval - width;
                  end else begin
                     low_cnt <= low_cnt - 32'h1;
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: bit 0 target match, bit 1 pulse train stopped at the stop time
   always_comb begin
      next_status = stat_rd ? 2'h0 : status;
      if (hit && int_role) begin
         next_status[0] = 1'b1;
      end
      if (state == FPPS_LOW && stop_pending && hit && pulse_role) begin
         next_status[1] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 2'h0;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         irq <= |(next_status & mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read data, zero-wait answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `FPPS_ADDR_CTRL: begin
                  prdata <= {25'h0, mode, 5'h0};
               end
               `FPPS_ADDR_TSEC: begin
                  prdata <= target.sec;
               end
               `FPPS_ADDR_TNS: begin
                  prdata <= {busy, target.ns[30:0]};
               end
               `FPPS_ADDR_WIDTH: begin
                  prdata <= width;
               end
               `FPPS_ADDR_INTVL: begin
                  prdata <= interval;
               end
               `FPPS_ADDR_STAT: begin
                  prdata <= {30'h0, status};
               end
               `FPPS_ADDR_MASK: begin
                  prdata <= {30'h0, mask};
               end
               default: begin
                  pslverr <= 1'b1;
               end
            endcase
         end else if (psel && !penable) begin
            pslverr <= !(paddr == `FPPS_ADDR_CTRL || paddr == `FPPS_ADDR_TSEC
                         || paddr == `FPPS_ADDR_TNS
                         || paddr == `FPPS_ADDR_WIDTH
                         || paddr == `FPPS_ADDR_INTVL
                         || paddr == `FPPS_ADDR_MASK);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_INT_ONLY_NO_PULSE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (mode == FPPS_MODE_INT && state == FPPS_WAIT_SINGLE && $stable(mode))
      |=> !$rose(pps_out))
      else $error("pulse started in interrupt-only mode");
   AST_PULSE_MODE_START: assert property (
      @(posedge pclk) disable iff (!presetn)
      (hit && pulse_role && state == FPPS_WAIT_SINGLE && cmd_wr == 4'h0)
      |=> pps_out)
      else $error("pulse did not start at target");
   AST_PULSE_ONLY_NO_INT: assert property (
      @(posedge pclk) disable iff (!presetn)
      (hit && mode == FPPS_MODE_PULSE && !status[0])
      |=> !status[0])
      else $error("target interrupt raised in pulse-only mode");
   AST_SINGLE_ARMS: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr == FPPS_CMD_SINGLE)
      |=> state == FPPS_WAIT_SINGLE)
      else $error("single pulse command not armed");
   AST_WIDTH_TWO: assert property (
      @(posedge pclk) disable iff (!presetn)
      ($rose(pps_out) && high_cnt == 32'h2 && cmd_wr == 4'h0)
      |=> pps_out ##1 !pps_out)
      else $error("pulse width wrong");
   AST_CMD_READS_ZERO: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == `FPPS_ADDR_CTRL)
      |=> prdata[3:0] == 4'h0)
      else $error("command field did not read as zero");
   AST_CANCEL_SINGLE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr == FPPS_CMD_CANCEL && state == FPPS_WAIT_SINGLE)
      |=> state == FPPS_IDLE)
      else $error("cancel did not drop pending single pulse");
   AST_MERGE_SINGLE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr == FPPS_CMD_SINGLE && pps_out)
      |=> state == FPPS_WAIT_SINGLE && pps_out)
      else $error("single pulse command did not replace the old one");
   AST_TRAIN_ARMS: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr == FPPS_CMD_TRAIN)
      |=> state == FPPS_WAIT_TRAIN)
      else $error("train command not armed");
   AST_TRAIN_REPEATS: assert property (
      @(posedge pclk) disable iff (!presetn)
      (state == FPPS_LOW && low_cnt == 32'h1 && !stop_pending
      && cmd_wr == 4'h0)
      |=> pps_out && state == FPPS_HIGH)
      else $error("train did not repeat");
   AST_STOP_AT_TIME: assert property (
      @(posedge pclk) disable iff (!presetn)
      (state == FPPS_LOW && stop_pending && hit && pulse_role
      && cmd_wr == 4'h0)
      |=> state == FPPS_IDLE && !pps_out)
      else $error("train did not stop at the stop time");
   AST_STOP_NOW: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr == FPPS_CMD_STOP_NOW)
      |=> !pps_out && state == FPPS_IDLE)
      else $error("stop now did not stop");
   AST_UNSTOP: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr == FPPS_CMD_UNSTOP)
      |=> !stop_pending)
      else $error("stop not revoked");
   AST_CANCEL: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr == FPPS_CMD_CANCEL && state == FPPS_WAIT_TRAIN)
      |=> state == FPPS_IDLE && !pps_out)
      else $error("cancel did not clear pending pulse");
   AST_BUSY_SET: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `FPPS_ADDR_TNS)
      |=> busy)
      else $error("busy flag not set on target load");
   AST_BUSY_READ: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == `FPPS_ADDR_TNS)
      |=> prdata[31] == $past(busy))
      else $error("busy flag read back wrong");
   AST_INT_RAISE: assert property (
      @(posedge pclk) disable iff (!presetn)
      (hit && int_role)
      |=> status[0])
      else $error("target interrupt missed");
   AST_MODE_DROPS: assert property (
      @(posedge pclk) disable iff (!presetn)
      (mode_wr && mode == FPPS_MODE_INT && !hit)
      |=> !busy)
      else $error("mode change kept the pending target");
endmodule

// ---- hw/fpps_params.svh ----
// Register offsets, field positions and reset values for the PPS unit
`ifndef FPPS_PARAMS_SVH
`define FPPS_PARAMS_SVH
`define FPPS_ADDR_CTRL 12'h000
`define FPPS_ADDR_TSEC 12'h004
`define FPPS_ADDR_TNS 12'h008
`define FPPS_ADDR_WIDTH 12'h00C
`define FPPS_ADDR_INTVL 12'h010
`define FPPS_ADDR_STAT 12'h014
`define FPPS_ADDR_MASK 12'h018
`define FPPS_CMD_LSB 0
`define FPPS_CMD_MSB 3
`define FPPS_MODE_LSB 5
`define FPPS_MODE_MSB 6
`define FPPS_BUSY_BIT 31
`define FPPS_MODE_RST 2'h0
`define FPPS_WIDTH_RST 32'h00000001
`define FPPS_INTVL_RST 32'h00000002
`endif

// ---- hw/fpps_pkg.sv ----
// Types of the flexible PPS target time unit
package fpps_pkg;
   typedef enum logic [3:0] {
      FPPS_CMD_NONE = 4'h0,
      FPPS_CMD_SINGLE = 4'h1,
      FPPS_CMD_TRAIN = 4'h2,
      FPPS_CMD_CANCEL = 4'h3,
      FPPS_CMD_STOP_AT = 4'h4,
      FPPS_CMD_STOP_NOW = 4'h5,
      FPPS_CMD_UNSTOP = 4'h6
   } fpps_cmd_t;
   typedef enum logic [1:0] {
      FPPS_MODE_INT = 2'h0,
      FPPS_MODE_RSVD = 2'h1,
      FPPS_MODE_BOTH = 2'h2,
      FPPS_MODE_PULSE = 2'h3
   } fpps_mode_t;
   typedef enum {
      FPPS_IDLE,
      FPPS_WAIT_SINGLE,
      FPPS_WAIT_TRAIN,
      FPPS_HIGH,
      FPPS_LOW
   } fpps_state_t;
   typedef struct packed {
      logic [31:0] sec;
      logic [31:0] ns;
   } fpps_time_t;
endpackage

// ---- verif/fpps_sink.sv ----
// Model of the equipment that consumes the pulse output
module fpps_sink
   import fpps_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pulse input
   input wire logic pps_out,
   // Measurements
   output int pulses,
   output int hi_len,
   output int period
);
   timeunit 1ns;
   timeprecision 1ns;
   logic prev;
   int gap;
   int hi_cnt;
   // Counts rising edges, high cycles and cycles between rising edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 1'b0;
         gap <= 0;
         hi_cnt <= 0;
         pulses <= 0;
         hi_len <= 0;
         period <= 0;
      end else begin
         prev <= pps_out;
         gap <= (pps_out && !prev) ? 1 : gap + 1;
         hi_cnt <= (pps_out && !prev) ? 1 : hi_cnt + int'(pps_out);
         if (pps_out && !prev) begin
            pulses <= pulses + 1;
            period <= gap;
         end
         if (!pps_out && prev) begin
            hi_len <= hi_cnt;
         end
      end
   end
endmodule

// ---- verif/flexible_pps_target_time_unit_test.sv ----
// Testbench of the flexible PPS target time unit
`include "fpps_params.svh"
module flexible_pps_target_time_unit_test;
   import fpps_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      logic [1:0] mode;
      logic [31:0] mask, width;
      int np;
      logic irq;
      logic [31:0] st;
   } fpps_row_t;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic pready, pslverr, pps_out, irq, e;
   fpps_time_t sys_time = '0;
   int pulses, hi_len, period, p, i, err_count = 0, total_checks = 0;
   fpps_row_t rows [5] = '{'{0, 1, 1, 0, 1, 1}, '{2, 1, 1, 1, 1, 1},
      '{3, 1, 2, 1, 0, 0}, '{0, 0, 4, 0, 0, 1}, '{2, 0, 7, 1, 0, 1}};
   fpps_unit i_fpps_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sys_time(sys_time), .pps_out(pps_out), .irq(irq));
   fpps_sink i_fpps_sink (.pclk(pclk), .presetn(presetn), .pps_out(pps_out),
      .pulses(pulses), .hi_len(hi_len), .period(period));
   always #20 pclk = ~pclk;
   always @(posedge pclk) sys_time.ns <= sys_time.ns + 32'h1;
   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         end_of_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      chk(r, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Polls the busy flag before the target is rewritten
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, `FPPS_ADDR_TNS, '0);
         n++;
      end while (r[31] !== 1'b0 && n < 100);
      if (n >= 100) begin
         err_count++;
         end_of_test();
      end
   endtask
   task automatic arm(input logic [31:0] dt);
      wr(`FPPS_ADDR_TNS, sys_time.ns + dt);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge pclk);
      err_count++;
      end_of_test();
   end
   initial begin
      cyc(16);
      presetn <= 1'b1;
      chk(pps_out, 0);
      chk(irq, 0);
      rd_chk(`FPPS_ADDR_CTRL, 32'h0);
      rd_chk(`FPPS_ADDR_WIDTH, `FPPS_WIDTH_RST);
      rd_chk(`FPPS_ADDR_INTVL, `FPPS_INTVL_RST);
      rd_chk(`FPPS_ADDR_STAT, 32'h0);
      wr(12'h01C, 32'hFFFFFFFF);
      chk(e, 1);
      rd_chk(12'h01C, 32'h0);
      chk(e, 1);
      wr(`FPPS_ADDR_TSEC, 32'h0);
      $display("Test reset done");
      foreach (rows[k]) begin
         wr(`FPPS_ADDR_CTRL, {25'h0, rows[k].mode, 5'h00});
         wr(`FPPS_ADDR_MASK, rows[k].mask);
         wr(`FPPS_ADDR_WIDTH, rows[k].width);
         wait_idle();
         p = pulses;
         arm(24);
         apb(1'b0, `FPPS_ADDR_TNS, '0);
         chk(r[31], 1);
         wr(`FPPS_ADDR_CTRL, {25'h0, rows[k].mode, 5'h01});
         rd_chk(`FPPS_ADDR_CTRL, {25'h0, rows[k].mode, 5'h00});
         wait_idle();
         cyc(int'(rows[k].width) + 3);
         chk(pulses - p, rows[k].np);
         if (rows[k].np > 0) chk(hi_len, rows[k].width);
         chk(irq, rows[k].irq);
         rd_chk(`FPPS_ADDR_STAT, rows[k].st);
         chk(irq, 0);
      end
      $display("Test mode table done");
      wr(`FPPS_ADDR_CTRL, 32'h60);
      for (i = 1; i < 3; i++) begin
         wait_idle();
         p = pulses;
         arm(40);
         wr(`FPPS_ADDR_CTRL, 32'h60 | i);
         wr(`FPPS_ADDR_CTRL, 32'h63);
         cyc(60);
         chk(pulses, p);
      end
      $display("Test cancel done");
      wr(`FPPS_ADDR_WIDTH, 32'h3);
      wr(`FPPS_ADDR_INTVL, 32'h8);
      wr(`FPPS_ADDR_CTRL, 32'h40);
      wait_idle();
      arm(20);
      wr(`FPPS_ADDR_CTRL, 32'h42);
      p = pulses;
      cyc(80);
      chk(pulses - p >= 6, 1);
      chk(hi_len, 3);
      chk(period, 8);
      rd_chk(`FPPS_ADDR_STAT, 32'h1);
      wait_idle();
      arm(40);
      wr(`FPPS_ADDR_CTRL, 32'h44);
      wr(`FPPS_ADDR_CTRL, 32'h46);
      p = pulses;
      cyc(100);
      chk(pulses - p >= 11, 1);
      wait_idle();
      arm(20);
      wr(`FPPS_ADDR_CTRL, 32'h44);
      cyc(40);
      p = pulses;
      cyc(40);
      chk(pulses, p);
      rd_chk(`FPPS_ADDR_STAT, 32'h3);
      $display("Test train done");
      wait_idle();
      arm(20);
      wr(`FPPS_ADDR_CTRL, 32'h42);
      cyc(40);
      wr(`FPPS_ADDR_CTRL, 32'h45);
      cyc(2);
      chk(pps_out, 0);
      p = pulses;
      cyc(40);
      chk(pulses, p);
      rd_chk(`FPPS_ADDR_STAT, 32'h1);
      $display("Test stop now done");
      wr(`FPPS_ADDR_CTRL, 32'h0);
      wr(`FPPS_ADDR_MASK, 32'h1);
      wait_idle();
      arm(30);
      wr(`FPPS_ADDR_CTRL, 32'h60);
      apb(1'b0, `FPPS_ADDR_TNS, '0);
      chk(r[31], 0);
      cyc(40);
      chk(irq, 0);
      rd_chk(`FPPS_ADDR_STAT, 32'h0);
      $display("Test mode change done");
      wr(`FPPS_ADDR_WIDTH, 32'h14);
      p = pulses;
      arm(20);
      wr(`FPPS_ADDR_CTRL, 32'h61);
      wait_idle();
      arm(12);
      wr(`FPPS_ADDR_CTRL, 32'h61);
      cyc(60);
      chk(pulses - p, 1);
      chk(hi_len > 32, 1);
      $display("Test merge done");
      end_of_test();
   end
endmodule
